/* File: rtl/cep_pkg.sv */
// Shared constants and state types of the serial programming link.
// Assumes a 200 MHz system clock on both ends of the link.
package cep_pkg;
  // System clock
  localparam int CLK_PERIOD_NS = 5;
  // Self-timed write cycle, longest time
  localparam int WR_TIME_MS = 20;
  localparam int WR_CYCLES = WR_TIME_MS * 1000000 / CLK_PERIOD_NS;
  // Quarter of a serial clock bit, least time (100 kHz bit rate)
  localparam int SCL_QTR_NS = 2500;
  localparam int SCL_QTR_CYCLES =
    (SCL_QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Memory organisation
  localparam int PAGE_BYTES = 128;
  localparam int PAGE_W = 7;
  localparam int ADDR_W = 24;
  localparam int MEM_ADDR_W = 17;
  localparam int HDR_ADDR_BYTES = 3;
  // Bit slot of the acknowledge within a byte
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [2:0] LAST_BIT = 3'h7;
  // Device address, value is arbitrary
  localparam logic [6:0] DEV_ADDR_DEF = 7'h2b;
  // Top address byte selecting the security bytes
  localparam logic [7:0] SEC_ADDR_TOP = 8'h80;
  localparam logic [7:0] BYTE_ONES = 8'hff;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // Read/write select value in the device address byte
  localparam logic RW_WRITE = 1'b0;

  typedef enum logic [5:0] {
    D_IDLE = 6'h01,
    D_RX = 6'h02,
    D_RXACK = 6'h04,
    D_TX = 6'h08,
    D_TXACK = 6'h10,
    D_BUSY = 6'h20
  } cep_dev_state_t;

  typedef enum logic [3:0] {
    H_IDLE = 4'h1,
    H_START = 4'h2,
    H_BYTE = 4'h4,
    H_STOP = 4'h8
  } cep_host_state_t;
endpackage

/* File: rtl/cep_link_if.sv */
// Two-wire programming link between programmer and EEPROM.
// The data wire is open drain with a pull-up; this interface resolves it.
`timescale 1ns/10ps
interface cep_link_if;
  logic serialClock;
  logic programModeSelN;
  logic devDataOut;
  logic devDataOe;
  logic hostDataOut;
  logic hostDataOe;
  logic serialData;

  // Wired-AND: pulled high unless an enabled driver pulls it low
  assign serialData = ~((devDataOe & ~devDataOut) |
                        (hostDataOe & ~hostDataOut));

  modport device (
    input serialClock,
    input programModeSelN,
    input serialData,
    output devDataOut,
    output devDataOe
  );

  modport host (
    output serialClock,
    output programModeSelN,
    output hostDataOut,
    output hostDataOe,
    input serialData
  );
endinterface

/* File: rtl/cep_eeprom_end.sv */
// EEPROM end of the two-wire programming link: page buffer, array,
// self-timed write cycle and security byte handling.
// Assumes the link pins come from another domain and are synchronised.
//
// Summary of operation
// - Data line only pulled low, pull-up for high
// - Programmer sends instruction, data, read acknowledges
// - Receiver of each byte acknowledges it low, except the last read byte
// - Array reads zero until explicitly written
// - Data changes only while clock low
// - Start falls, Stop rises, clock high
// - Start abandons everything, awaits device address
// - Stop after write starts 20 ms cycle
// - Programmer holds mode select low meanwhile
// - Data bytes travel least significant bit first
// - Programmer sends 128-byte pages
// - Address increments; low seven bits wrap on writes, reads carry on
// - Write: device byte, three address bytes, data
// - No acknowledge at all during write cycle
// - Programmer polls with Start plus device address
// - Programmer may instead wait 20 ms
// - Pages rewritable without touching other pages
// - Messages framed, eight bits plus acknowledge
// - Secured: no data out; clearing erases all
// - Programmer clears security with zero writes twice; here one zero write clears it
`timescale 1ns/10ps
module cep_eeprom_end #(
  parameter int WR_CYCLES = cep_pkg::WR_CYCLES,
  parameter int MEM_ADDR_W = cep_pkg::MEM_ADDR_W,
  parameter logic [6:0] DEV_ADDR = cep_pkg::DEV_ADDR_DEF
) (
  input logic clk,
  input logic rst,
  cep_link_if.device link,
  output logic busy,
  output logic secured
);
  localparam int PW = cep_pkg::PAGE_W;
  localparam int PG_W = MEM_ADDR_W - PW;
  localparam int NPAGES = 1 << PG_W;
  localparam int WC_W = $clog2(WR_CYCLES + 1);
  localparam logic [WC_W-1:0] WC_LAST = WC_W'(WR_CYCLES - 1);
  localparam logic [WC_W-1:0] WC_PAGE = WC_W'(cep_pkg::PAGE_BYTES);

  if (WR_CYCLES <= cep_pkg::PAGE_BYTES) begin : g_chk_wr
    $error("WR_CYCLES must exceed the page size");
  end
  if (MEM_ADDR_W <= PW || MEM_ADDR_W > cep_pkg::ADDR_W) begin : g_chk_mem
    $error("MEM_ADDR_W out of range");
  end

  // Array and page buffer
  logic [7:0] mem [1 << MEM_ADDR_W];
  logic [7:0] pageBuf [cep_pkg::PAGE_BYTES];

  // Two-stage synchronisers for the pins
  logic [1:0] sclSync_ff, sdaSync_ff, selSync_ff;
  logic sclPrev_ff, sdaPrev_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      sclSync_ff <= 2'h3;
      sdaSync_ff <= 2'h3;
      selSync_ff <= 2'h3;
      sclPrev_ff <= 1'b1;
      sdaPrev_ff <= 1'b1;
    end else begin
      sclSync_ff <= {sclSync_ff[0], link.serialClock};
      sdaSync_ff <= {sdaSync_ff[0], link.serialData};
      selSync_ff <= {selSync_ff[0], link.programModeSelN};
      sclPrev_ff <= sclSync_ff[1];
      sdaPrev_ff <= sdaSync_ff[1];
    end
  end

  logic sclHi, sdaHi, modeOn, sclRise, sclFall, startCond, stopCond;
  assign sclHi = sclSync_ff[1];
  assign sdaHi = sdaSync_ff[1];
  assign modeOn = ~selSync_ff[1];
  assign sclRise = sclHi & ~sclPrev_ff;
  assign sclFall = ~sclHi & sclPrev_ff;
  // Data moving while the clock is high is framing, never a bit
  assign startCond = sclHi & sclPrev_ff & sdaPrev_ff & ~sdaHi;
  assign stopCond = sclHi & sclPrev_ff & ~sdaPrev_ff & sdaHi;

  cep_pkg::cep_dev_state_t state_ff, nxt_state;
  logic [3:0] bitCnt_ff, nxt_bitCnt;
  logic [7:0] shift_ff, nxt_shift;
  logic [2:0] byteIdx_ff, nxt_byteIdx;
  logic [cep_pkg::ADDR_W-1:0] addr_ff, nxt_addr;
  logic [PG_W-1:0] wrPage_ff, nxt_wrPage;
  logic [WC_W-1:0] wrCnt_ff, nxt_wrCnt;
  logic [NPAGES-1:0] pageValid_ff, nxt_pageValid;
  logic [cep_pkg::PAGE_BYTES-1:0] loaded_ff, nxt_loaded;
  logic readMode_ff, nxt_readMode, oe_ff, nxt_oe, mAck_ff, nxt_mAck;
  logic secure_ff, nxt_secure, secMsg_ff, nxt_secMsg;
  logic allOnes_ff, nxt_allOnes, allZero_ff, nxt_allZero;
  logic anyData_ff, nxt_anyData, busy_ff, nxt_busy;
  logic bufWe, memWe;
  logic [PW-1:0] bufIdx, cIdx;
  logic [MEM_ADDR_W-1:0] memAddr, rdAddr;
  logic [7:0] memWdata, rdByte;

  // Byte handed out on a read; secured parts release the line
  always_comb begin
    rdAddr = (state_ff == cep_pkg::D_TXACK) ?
      MEM_ADDR_W'(addr_ff + 1'b1) : addr_ff[MEM_ADDR_W-1:0];
    if (secure_ff)
      rdByte = cep_pkg::BYTE_ONES;
    else if (pageValid_ff[rdAddr[MEM_ADDR_W-1:PW]])
      rdByte = mem[rdAddr];
    else
      rdByte = cep_pkg::BYTE_ZERO; // Never written reads as zero
  end

  // Protocol engine next state
  always_comb begin
    nxt_state = state_ff;
    nxt_bitCnt = bitCnt_ff;
    nxt_shift = shift_ff;
    nxt_byteIdx = byteIdx_ff;
    nxt_addr = addr_ff;
    nxt_wrPage = wrPage_ff;
    nxt_wrCnt = wrCnt_ff;
    nxt_pageValid = pageValid_ff;
    nxt_loaded = loaded_ff;
    nxt_readMode = readMode_ff;
    nxt_oe = oe_ff;
    nxt_mAck = mAck_ff;
    nxt_secure = secure_ff;
    nxt_secMsg = secMsg_ff;
    nxt_allOnes = allOnes_ff;
    nxt_allZero = allZero_ff;
    nxt_anyData = anyData_ff;
    bufWe = 1'b0;
    bufIdx = addr_ff[PW-1:0];
    memWe = 1'b0;
    cIdx = wrCnt_ff[PW-1:0];
    memAddr = {wrPage_ff, cIdx};
    memWdata = loaded_ff[cIdx] ? pageBuf[cIdx] : cep_pkg::BYTE_ZERO;
    case (state_ff)
      cep_pkg::D_IDLE: begin
        nxt_oe = 1'b0;
      end
      cep_pkg::D_RX: begin
        if (sclRise && bitCnt_ff != cep_pkg::ACK_SLOT) begin
          nxt_bitCnt = bitCnt_ff + 1'b1;
          if (byteIdx_ff > 3'(cep_pkg::HDR_ADDR_BYTES))
            nxt_shift = {sdaHi, shift_ff[7:1]}; // LSB first
          else
            nxt_shift = {shift_ff[6:0], sdaHi}; // Header MSB first
        end else if (sclFall && bitCnt_ff == cep_pkg::ACK_SLOT) begin
          nxt_oe = 1'b1; // Acknowledge the byte; withdrawn below on a foreign device address
          nxt_state = cep_pkg::D_RXACK;
          if (byteIdx_ff != 3'(cep_pkg::HDR_ADDR_BYTES + 1))
            nxt_byteIdx = byteIdx_ff + 1'b1;
          if (byteIdx_ff == 3'h0) begin
            nxt_readMode = shift_ff[0];
            if (shift_ff[7:1] != DEV_ADDR) begin
              nxt_oe = 1'b0;
              nxt_state = cep_pkg::D_IDLE;
            end
          end else if (byteIdx_ff <= 3'(cep_pkg::HDR_ADDR_BYTES)) begin
            nxt_addr = {addr_ff[15:0], shift_ff}; // MS byte first
            if (byteIdx_ff == 3'h1)
              nxt_secMsg = (shift_ff == cep_pkg::SEC_ADDR_TOP);
          end else begin
            if (!anyData_ff)
              nxt_wrPage = addr_ff[MEM_ADDR_W-1:PW];
            nxt_anyData = 1'b1;
            if (secMsg_ff) begin
              nxt_allOnes = allOnes_ff & (shift_ff == cep_pkg::BYTE_ONES);
              nxt_allZero = allZero_ff & (shift_ff == cep_pkg::BYTE_ZERO);
            end else begin
              bufWe = 1'b1; // First byte at sent address
              nxt_loaded[addr_ff[PW-1:0]] = 1'b1;
            end
            // Only the low bits count, wrapping in the page
            nxt_addr[PW-1:0] = addr_ff[PW-1:0] + 1'b1;
          end
        end
      end
      cep_pkg::D_RXACK: begin
        if (sclFall) begin
          nxt_bitCnt = 4'h0;
          if (readMode_ff) begin
            nxt_shift = rdByte;
            nxt_oe = ~rdByte[0];
            nxt_state = cep_pkg::D_TX;
          end else begin
            nxt_oe = 1'b0;
            nxt_state = cep_pkg::D_RX;
          end
        end
      end
      cep_pkg::D_TX: begin
        if (sclFall) begin
          if (bitCnt_ff[2:0] == cep_pkg::LAST_BIT) begin
            nxt_oe = 1'b0;
            nxt_state = cep_pkg::D_TXACK;
          end else begin
            nxt_bitCnt = bitCnt_ff + 1'b1;
            nxt_shift = {1'b0, shift_ff[7:1]};
            nxt_oe = ~shift_ff[1]; // Pull low only, never drive high
          end
        end
      end
      cep_pkg::D_TXACK: begin
        if (sclRise)
          nxt_mAck = ~sdaHi;
        if (sclFall) begin
          nxt_bitCnt = 4'h0;
          if (mAck_ff) begin
            nxt_addr = addr_ff + 1'b1;
            nxt_shift = rdByte;
            nxt_oe = ~rdByte[0];
            nxt_state = cep_pkg::D_TX;
          end else begin
            nxt_state = cep_pkg::D_IDLE; // Programmer ended the read
          end
        end
      end
      cep_pkg::D_BUSY: begin
        // Link ignored, nothing acknowledged until done
        nxt_oe = 1'b0;
        nxt_wrCnt = wrCnt_ff + 1'b1;
        // Only the addressed page is touched
        if (!secMsg_ff && wrCnt_ff < WC_PAGE)
          memWe = loaded_ff[cIdx] | ~pageValid_ff[wrPage_ff];
        if (wrCnt_ff == WC_LAST) begin
          if (!secMsg_ff)
            nxt_pageValid[wrPage_ff] = 1'b1;
          nxt_loaded = '0;
          nxt_anyData = 1'b0;
          nxt_state = cep_pkg::D_IDLE;
        end
      end
      default: begin
        nxt_oe = 1'b0;
        nxt_state = cep_pkg::D_IDLE;
      end
    endcase
    // Framing outranks the bit engine outside the write cycle
    if (state_ff != cep_pkg::D_BUSY) begin
      if (!modeOn) begin
        nxt_oe = 1'b0;
        nxt_state = cep_pkg::D_IDLE;
      end else if (startCond) begin
        // Start drops any half-finished message
        nxt_state = cep_pkg::D_RX;
        nxt_bitCnt = 4'h0;
        nxt_byteIdx = 3'h0;
        nxt_oe = 1'b0;
        nxt_secMsg = 1'b0;
        nxt_allOnes = 1'b1;
        nxt_allZero = 1'b1;
        nxt_anyData = 1'b0;
        nxt_loaded = '0;
      end else if (stopCond) begin
        nxt_oe = 1'b0;
        nxt_wrCnt = '0;
        if (anyData_ff && !readMode_ff) begin
          nxt_state = cep_pkg::D_BUSY; // Stop launches write
          if (secMsg_ff && allOnes_ff) begin
            nxt_secure = 1'b1;
          end else if (secMsg_ff && allZero_ff && secure_ff) begin
            nxt_secure = 1'b0; // Clearing security wipes all
            nxt_pageValid = '0;
          end
        end else begin
          nxt_state = cep_pkg::D_IDLE;
        end
      end
    end
    nxt_busy = (nxt_state == cep_pkg::D_BUSY);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= cep_pkg::D_IDLE;
      bitCnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      byteIdx_ff <= 3'h0;
      addr_ff <= '0;
      wrPage_ff <= '0;
      wrCnt_ff <= '0;
      pageValid_ff <= '0;
      loaded_ff <= '0;
      readMode_ff <= 1'b0;
      oe_ff <= 1'b0;
      mAck_ff <= 1'b0;
      secure_ff <= 1'b0;
      secMsg_ff <= 1'b0;
      allOnes_ff <= 1'b1;
      allZero_ff <= 1'b1;
      anyData_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      bitCnt_ff <= nxt_bitCnt;
      shift_ff <= nxt_shift;
      byteIdx_ff <= nxt_byteIdx;
      addr_ff <= nxt_addr;
      wrPage_ff <= nxt_wrPage;
      wrCnt_ff <= nxt_wrCnt;
      pageValid_ff <= nxt_pageValid;
      loaded_ff <= nxt_loaded;
      readMode_ff <= nxt_readMode;
      oe_ff <= nxt_oe;
      mAck_ff <= nxt_mAck;
      secure_ff <= nxt_secure;
      secMsg_ff <= nxt_secMsg;
      allOnes_ff <= nxt_allOnes;
      allZero_ff <= nxt_allZero;
      anyData_ff <= nxt_anyData;
      busy_ff <= nxt_busy;
    end
  end

  // Storage has no reset; page valid bits stand in for blank contents
  always_ff @(posedge clk) begin
    if (bufWe)
      pageBuf[bufIdx] <= shift_ff;
    if (memWe)
      mem[memAddr] <= memWdata;
  end

  assign link.devDataOut = 1'b0; // Open drain, low level only
  assign link.devDataOe = oe_ff;
  assign busy = busy_ff;
  assign secured = secure_ff;
endmodule

/* File: rtl/cep_programmer_end.sv */
// Programmer end of the two-wire link: makes the serial clock by a
// divider and runs one message per request. Expects a pulled-up data wire.
`timescale 1ns/10ps
module cep_programmer_end #(
  parameter int QTR_CYCLES = cep_pkg::SCL_QTR_CYCLES,
  parameter int CNT_W = 9,
  parameter logic [6:0] DEV_ADDR = cep_pkg::DEV_ADDR_DEF
) (
  input logic clk,
  input logic rst,
  cep_link_if.host link,
  input logic modeEnable,
  input logic reqStart,
  input logic reqRead,
  input logic [cep_pkg::ADDR_W-1:0] reqAddr,
  input logic [CNT_W-1:0] reqCount,
  input logic [7:0] wrData,
  output logic wrDataTake,
  output logic [7:0] rdData,
  output logic rdValid,
  output logic busy,
  output logic done,
  output logic nack
);
  localparam int QC_W = $clog2(QTR_CYCLES + 1);
  localparam logic [QC_W-1:0] QC_LAST = QC_W'(QTR_CYCLES - 1);
  localparam logic [1:0] HDR_LAST = 2'(cep_pkg::HDR_ADDR_BYTES);

  if (QTR_CYCLES < 4 || CNT_W < 8) begin : g_chk
    $error("QTR_CYCLES or CNT_W too small");
  end

  // Two-stage synchroniser for the data wire
  logic [1:0] sdaSync_ff;
  always_ff @(posedge clk) begin
    if (rst)
      sdaSync_ff <= 2'h3;
    else
      sdaSync_ff <= {sdaSync_ff[0], link.serialData};
  end

  cep_pkg::cep_host_state_t state_ff, nxt_state;
  logic [QC_W-1:0] qCnt_ff, nxt_qCnt;
  logic [1:0] q_ff, nxt_q, hdr_ff, nxt_hdr;
  logic [3:0] slot_ff, nxt_slot;
  logic [CNT_W-1:0] left_ff, nxt_left;
  logic [7:0] tx_ff, nxt_tx, rx_ff, nxt_rx, rdData_ff, nxt_rdData;
  logic [cep_pkg::ADDR_W-1:0] addr_ff, nxt_addr;
  logic read_ff, nxt_read, dataPh_ff, nxt_dataPh, ackOk_ff, nxt_ackOk;
  logic scl_ff, nxt_scl, oe_ff, nxt_oe, selN_ff, nxt_selN;
  logic take_ff, nxt_take, rdV_ff, nxt_rdV, busy_ff, nxt_busy;
  logic done_ff, nxt_done, nack_ff, nxt_nack;
  logic qTick, txBit;

  assign qTick = (qCnt_ff == QC_LAST);
  // Header bytes go MSB first, data bytes LSB first
  assign txBit = dataPh_ff ? tx_ff[slot_ff[2:0]] :
                 tx_ff[cep_pkg::LAST_BIT - slot_ff[2:0]];

  always_comb begin
    nxt_state = state_ff;
    nxt_qCnt = qTick ? '0 : qCnt_ff + 1'b1;
    nxt_q = qTick ? q_ff + 1'b1 : q_ff;
    nxt_hdr = hdr_ff;
    nxt_slot = slot_ff;
    nxt_left = left_ff;
    nxt_tx = tx_ff;
    nxt_rx = rx_ff;
    nxt_rdData = rdData_ff;
    nxt_addr = addr_ff;
    nxt_read = read_ff;
    nxt_dataPh = dataPh_ff;
    nxt_ackOk = ackOk_ff;
    nxt_scl = scl_ff;
    nxt_oe = oe_ff;
    // Mode select simply follows the user; holding and toggling
    // it around write cycles and security clearing is the user's job
    nxt_selN = ~modeEnable;
    nxt_take = 1'b0;
    nxt_rdV = 1'b0;
    nxt_done = 1'b0;
    nxt_nack = nack_ff;
    case (state_ff)
      cep_pkg::H_IDLE: begin
        nxt_scl = 1'b1;
        nxt_oe = 1'b0;
        nxt_qCnt = '0;
        nxt_q = 2'h0;
        if (reqStart) begin
          // Count of data bytes is the caller's; a page is 128
          nxt_state = cep_pkg::H_START;
          nxt_read = reqRead;
          nxt_addr = reqAddr;
          nxt_left = reqCount;
          nxt_tx = {DEV_ADDR, reqRead};
          nxt_hdr = 2'h0;
          nxt_slot = 4'h0;
          nxt_dataPh = 1'b0;
          nxt_nack = 1'b0;
        end
      end
      cep_pkg::H_START: begin
        if (qTick && q_ff == 2'h0)
          nxt_oe = 1'b1; // Data falls, clock high
        if (qTick && q_ff == 2'h1) begin
          nxt_scl = 1'b0;
          nxt_q = 2'h0;
          nxt_state = cep_pkg::H_BYTE;
        end
      end
      cep_pkg::H_BYTE: begin
        if (qTick) begin
          case (q_ff)
            2'h0: begin
              // Data moves only with the clock low
              if (slot_ff != cep_pkg::ACK_SLOT)
                nxt_oe = (dataPh_ff && read_ff) ? 1'b0 : ~txBit;
              else // Acknowledge read bytes, none on the last
                nxt_oe = dataPh_ff && read_ff && left_ff != CNT_W'(1);
            end
            2'h1: nxt_scl = 1'b1;
            2'h2: begin
              if (slot_ff == cep_pkg::ACK_SLOT)
                nxt_ackOk = ~sdaSync_ff[1];
              else if (dataPh_ff && read_ff)
                nxt_rx[slot_ff[2:0]] = sdaSync_ff[1];
            end
            default: begin
              nxt_scl = 1'b0;
              nxt_slot = slot_ff + 1'b1;
              if (slot_ff == cep_pkg::ACK_SLOT) begin
                nxt_slot = 4'h0;
                nxt_oe = 1'b0;
                if ((!dataPh_ff || !read_ff) && !ackOk_ff) begin
                  // Busy device: drop without Stop, caller retries
                  nxt_scl = 1'b1;
                  nxt_nack = 1'b1;
                  nxt_done = 1'b1;
                  nxt_state = cep_pkg::H_IDLE;
                end else if (dataPh_ff) begin
                  nxt_left = left_ff - 1'b1;
                  nxt_rdV = read_ff;
                  nxt_rdData = rx_ff;
                  if (left_ff == CNT_W'(1))
                    nxt_state = cep_pkg::H_STOP;
                  else if (!read_ff) begin
                    nxt_tx = wrData;
                    nxt_take = 1'b1;
                  end
                end else if (!read_ff && hdr_ff != HDR_LAST) begin
                  nxt_hdr = hdr_ff + 1'b1;
                  case (hdr_ff) // Address MS byte first
                    2'h0: nxt_tx = addr_ff[23:16];
                    2'h1: nxt_tx = addr_ff[15:8];
                    default: nxt_tx = addr_ff[7:0];
                  endcase
                end else if (left_ff == '0) begin
                  nxt_state = cep_pkg::H_STOP;
                end else begin
                  nxt_dataPh = 1'b1;
                  if (!read_ff) begin
                    nxt_tx = wrData;
                    nxt_take = 1'b1;
                  end
                end
              end
            end
          endcase
        end
      end
      cep_pkg::H_STOP: begin
        if (qTick) begin
          case (q_ff)
            2'h0: nxt_oe = 1'b1;
            2'h1: nxt_scl = 1'b1;
            2'h2: nxt_oe = 1'b0; // Data rises, clock high
            default: begin
              nxt_done = 1'b1;
              nxt_state = cep_pkg::H_IDLE;
            end
          endcase
        end
      end
      default: nxt_state = cep_pkg::H_IDLE;
    endcase
    nxt_busy = (nxt_state != cep_pkg::H_IDLE);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= cep_pkg::H_IDLE;
      qCnt_ff <= '0;
      q_ff <= 2'h0;
      hdr_ff <= 2'h0;
      slot_ff <= 4'h0;
      left_ff <= '0;
      tx_ff <= 8'h00;
      rx_ff <= 8'h00;
      rdData_ff <= 8'h00;
      addr_ff <= '0;
      read_ff <= 1'b0;
      dataPh_ff <= 1'b0;
      ackOk_ff <= 1'b0;
      scl_ff <= 1'b1;
      oe_ff <= 1'b0;
      selN_ff <= 1'b1;
      take_ff <= 1'b0;
      rdV_ff <= 1'b0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      nack_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      qCnt_ff <= nxt_qCnt;
      q_ff <= nxt_q;
      hdr_ff <= nxt_hdr;
      slot_ff <= nxt_slot;
      left_ff <= nxt_left;
      tx_ff <= nxt_tx;
      rx_ff <= nxt_rx;
      rdData_ff <= nxt_rdData;
      addr_ff <= nxt_addr;
      read_ff <= nxt_read;
      dataPh_ff <= nxt_dataPh;
      ackOk_ff <= nxt_ackOk;
      scl_ff <= nxt_scl;
      oe_ff <= nxt_oe;
      selN_ff <= nxt_selN;
      take_ff <= nxt_take;
      rdV_ff <= nxt_rdV;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
      nack_ff <= nxt_nack;
    end
  end

  assign link.serialClock = scl_ff;
  assign link.programModeSelN = selN_ff;
  assign link.hostDataOut = 1'b0;
  assign link.hostDataOe = oe_ff;
  assign wrDataTake = take_ff;
  assign rdData = rdData_ff;
  assign rdValid = rdV_ff;
  assign busy = busy_ff;
  assign done = done_ff;
  assign nack = nack_ff;
endmodule

/* File: dv/cep_link_props.sv */
// Checker on the wires of the programming link.
// Fed the link signals and the EEPROM busy level by the bench.
`timescale 1ns/10ps
module cep_link_props #(
  parameter int WR_CYCLES = 200
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic serialClock,
  input wire logic programModeSelN,
  input wire logic devDataOut,
  input wire logic devDataOe,
  input wire logic hostDataOut,
  input wire logic hostDataOe,
  input wire logic serialData,
  input wire logic busy
);
  logic [23:0] busyLen_ff;
  logic [23:0] nxt_busyLen;
  // Length of the write cycle, so it can be tied to the parameter
  always_comb nxt_busyLen = busy ? busyLen_ff + 24'h1 : 24'h0;
  always_ff @(posedge clk) busyLen_ff <= rst ? 24'h0 : nxt_busyLen;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence hostStart;
    serialClock && $rose(hostDataOe);
  endsequence
  sequence hostStop;
    serialClock && $fell(hostDataOe);
  endsequence
  drive_low_a: assert property (!devDataOut && !hostDataOut)
    else $error("data line driven high");
  busy_quiet_a: assert property (busy |-> !devDataOe)
    else $error("EEPROM drives while busy");
  clk_high_a: assert property (serialClock && $past(serialClock)
    |-> $stable(devDataOe)) else $error("EEPROM data moved, clock high");
  ack_late_a: assert property ($rose(devDataOe)
    |-> !serialClock && $past(!serialClock, 2)) else $error("late answer");
  start_shape_a: assert property (hostStart
    |-> serialClock[*4] ##[1:8] !serialClock) else $error("bad start");
  stop_idle_a: assert property (hostStop |-> serialClock[*4])
    else $error("clock moved after stop");
  sel_idle_a: assert property (programModeSelN[*4] |-> !devDataOe)
    else $error("EEPROM active out of mode");
  busy_stop_a: assert property ($rose(busy)
    |-> serialClock && serialData) else $error("busy without stop");
  busy_len_a: assert property ($fell(busy)
    |-> busyLen_ff + 24'h1 >= WR_CYCLES && busyLen_ff <= WR_CYCLES + 1)
    else $error("write cycle length wrong");
endmodule

/* File: dv/tb_config_eeprom_serial_program.sv */
// Bench: programmer end and EEPROM end joined over the link interface.
// Assumes the interface resolves the pulled-up data wire.
`timescale 1ns/10ps
module tb_config_eeprom_serial_program;
  localparam int WR = 2000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reqStart = 1'b0;
  logic reqRead = 1'b0;
  logic [23:0] reqAddr = 24'h0;
  logic [8:0] reqCount = 9'h0;
  logic [7:0] rdData;
  logic wrDataTake, rdValid, hBusy, done, nack, eBusy, sec;
  logic modeEn = 1'b1;
  logic [1:0] wi = 2'h0;
  logic [9:0] sh = 10'h0;
  logic [7:0] wbuf [4] = '{8'ha5, 8'h3c, 8'h81, 8'h00};
  logic [7:0] rq [$];
  int failures = 0;
  int n_compared = 0;
  int cyc = 0;
  cep_link_if link();
  cep_programmer_end #(.QTR_CYCLES(8)) cep_programmer_end_inst (
    .clk(clk), .rst(rst), .link(link.host), .modeEnable(modeEn),
    .reqStart(reqStart), .reqRead(reqRead), .reqAddr(reqAddr),
    .reqCount(reqCount), .wrData(wbuf[wi]), .wrDataTake(wrDataTake),
    .rdData(rdData), .rdValid(rdValid), .busy(hBusy), .done(done),
    .nack(nack));
  cep_eeprom_end #(.WR_CYCLES(WR)) cep_eeprom_end_inst (.clk(clk),
    .rst(rst), .link(link.device), .busy(eBusy), .secured(sec));
  cep_link_props #(.WR_CYCLES(WR)) cep_link_props_inst (.clk(clk),
    .rst(rst), .serialClock(link.serialClock),
    .programModeSelN(link.programModeSelN), .devDataOut(link.devDataOut),
    .devDataOe(link.devDataOe), .hostDataOut(link.hostDataOut),
    .hostDataOe(link.hostDataOe), .serialData(link.serialData),
    .busy(eBusy));
  initial forever #2.5 clk = ~clk;
  // Step write bytes and gather read bytes off the sampling edge
  always @(negedge clk) begin
    if (wrDataTake) wi <= wi + 2'h1;
    if (rdValid) rq.push_back(rdData);
  end
  // Wire history, one bit per rising serial clock
  always @(posedge link.serialClock) sh <= {sh[8:0], link.serialData};
  // Hang guard, well above the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      failures++;
      report_and_stop();
    end
  end
  task automatic chk(string nm, logic [9:0] got, logic [9:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One message; returns once the programmer reports done
  task automatic msg(logic rd, logic [23:0] a, logic [8:0] n);
    @(negedge clk);
    {reqRead, reqAddr, reqCount, reqStart} = {rd, a, n, 1'b1};
    wi = 2'h0;
    rq.delete();
    @(negedge clk);
    reqStart = 1'b0;
    chk("hbusy", 10'(hBusy), 10'h1);
    while (done !== 1'b1) @(negedge clk);
  endtask
  // Mode select released: the EEPROM must stay silent
  task automatic t_mode();
    modeEn = 1'b0;
    msg(1'b0, 24'h0, 9'h0);
    chk("off", 10'(nack), 10'h1);
    modeEn = 1'b1;
    $display("mode select test ended");
  endtask
  // Set security, read is hidden, clearing erases the pages
  task automatic t_sec();
    wbuf = '{4{8'hff}};
    msg(1'b0, 24'h800000, 9'h4);
    while (eBusy !== 1'b0) @(negedge clk);
    chk("sec", 10'(sec), 10'h1);
    msg(1'b1, 24'h0, 9'h1);
    chk("hide", 10'(rq[0]), 10'h0ff);
    wbuf = '{4{8'h00}};
    msg(1'b0, 24'h800000, 9'h4);
    while (eBusy !== 1'b0) @(negedge clk);
    chk("unsec", 10'(sec), 10'h0);
    msg(1'b0, 24'h000100, 9'h0);
    msg(1'b1, 24'h0, 9'h1);
    chk("erase", 10'(rq[0]), 10'h000);
    $display("security test ended");
  endtask
  task automatic t_page();
    msg(1'b0, 24'h00017e, 9'h3);
    chk("nack", 10'(nack), 10'h0);
    chk("busy", 10'(eBusy), 10'h1);
    msg(1'b0, 24'h00017e, 9'h0);
    chk("poll", 10'(nack), 10'h1);
    while (eBusy !== 1'b0) @(negedge clk);
    $display("page write test ended");
  endtask
  task automatic t_read();
    msg(1'b0, 24'h00017f, 9'h0);
    msg(1'b1, 24'h0, 9'h2);
    chk("rd0", 10'(rq[0]), 10'h03c);
    chk("rd1", 10'(rq[1]), 10'h000);
    msg(1'b0, 24'h000100, 9'h0);
    msg(1'b1, 24'h0, 9'h1);
    chk("wrap", 10'(rq[0]), 10'h081);
    chk("wire", sh, 10'h206);
    $display("read back test ended");
  endtask
  task automatic report_and_stop();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    t_page();
    t_read();
    t_mode();
    t_sec();
    report_and_stop();
  end
endmodule
